/* File: logic/flash_host_pkg.sv */
// Constants shared by the flash host controller and its pin cycle engine.
// Assumes a single 25 MHz core clock; all pin timing is counted in it.
package flash_host_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACCESS_NS = 120;
    localparam int WE_PULSE_NS = 50;
    localparam int RECOVERY_NS = 600;
    localparam int SYNC_STAGES = 2;
    // Least times round up to whole cycles
    localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WE_LOAD = 4'(WE_CYC - 1);
    localparam logic [3:0] RD_LOAD = 4'(ACC_CYC + SYNC_STAGES - 1);
    localparam logic [7:0] REC_LOAD = 8'(REC_CYC);

    // ---------------------------------------------------------------
    // Array geometry
    // ---------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int PARAM_BLOCK_W = 12;
    localparam int LOCK_SPAN_W = PARAM_BLOCK_W + 1;

    // ---------------------------------------------------------------
    // Register map (word index on the bus)
    // ---------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_WDATA = 3'h2;
    localparam logic [2:0] REG_RDATA = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_PD_BIT = 4;
    localparam int CTRL_WP_BIT = 5;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RECOV_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_LOCK_BIT = 3;
    localparam int ST_REJ_BIT = 4;
    localparam int ST_DEV_LSB = 8;
    localparam int DEV_READY_BIT = 7;

    typedef enum logic [2:0] {
        OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2,
        OP_SUSPEND = 3'h3, OP_RESUME = 3'h4, OP_CLRSTAT = 3'h5,
        OP_STATUS = 3'h6
    } op_t;

    // ---------------------------------------------------------------
    // Command codes written to the command front end
    // ---------------------------------------------------------------
    localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
    localparam logic [15:0] CMD_PROGRAM = 16'h0040;
    localparam logic [15:0] CMD_ERASE = 16'h0020;
    localparam logic [15:0] CMD_CONFIRM = 16'h00D0;
    localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
    localparam logic [15:0] CMD_RESUME = 16'h00D0;
    localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
    localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
endpackage

/* File: logic/flash_cycle_if.sv */
// One-cycle request/answer link from the sequencer to the pin engine.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface flash_cycle_if #(parameter int AW = 20) ();
    logic req;
    logic wr;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    modport seq (output req, wr, addr, wdata, input rdata, done);
    modport eng (input req, wr, addr, wdata, output rdata, done);
endinterface

/* File: logic/flash_cycle_engine.sv */
// Pin engine: turns one request into one asynchronous read or write
// cycle on the flash pins. Assumes the data pins are resolved outside.
`timescale 1ns/1ps
module flash_cycle_engine
    import flash_host_pkg::*;
#(
    parameter int AW = 20
) (
    input wire logic core_clk,
    input wire logic srst,
    flash_cycle_if.eng cyc,
    output logic [AW-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    typedef enum logic [3:0] {
        E_IDLE = 4'b0001, E_SETUP = 4'b0010,
        E_PULSE = 4'b0100, E_HOLD = 4'b1000
    } eng_state_t;

    eng_state_t state_r;
    logic wr_r;
    logic [3:0] cnt_r;
    logic [15:0] dq_s1_r;
    logic [15:0] dq_s2_r;

    // ---------------------------------------------------------------
    // Data pin synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        dq_s1_r <= flash_dq_in;
        dq_s2_r <= dq_s1_r;
    end

    // Cycle sequencing and strobe timing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= E_IDLE;
            cnt_r <= 4'h0;
            wr_r <= 1'b0;
        end else begin
            unique case (state_r)
                E_IDLE: begin
                    if (cyc.req) begin
                        wr_r <= cyc.wr;
                        state_r <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    cnt_r <= wr_r ? WE_LOAD : RD_LOAD;
                    state_r <= E_PULSE;
                end
                E_PULSE: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= E_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                E_HOLD: state_r <= E_IDLE;
            endcase
        end
    end

    // Pin drive; address and data stay put through the strobe's rise
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flash_addr <= '0;
            flash_dq_out <= 16'h0000;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else begin
            if (state_r == E_IDLE && cyc.req) begin
                flash_addr <= cyc.addr;
                flash_dq_out <= cyc.wdata;
                flash_dq_oe <= cyc.wr;
                flash_ce_n <= 1'b0;
            end
            if (state_r == E_SETUP) begin
                flash_we_n <= !wr_r;
                flash_oe_n <= wr_r;
            end
            if (state_r == E_PULSE && cnt_r == 4'h0) begin
                flash_we_n <= 1'b1;
                flash_oe_n <= 1'b1;
            end
            if (state_r == E_HOLD) begin
                flash_ce_n <= 1'b1;
                flash_dq_oe <= 1'b0;
            end
        end
    end

    // Answer to the sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cyc.done <= 1'b0;
            cyc.rdata <= 16'h0000;
        end else begin
            cyc.done <= (state_r == E_HOLD);
            if (state_r == E_PULSE && cnt_r == 4'h0 && !wr_r) begin
                cyc.rdata <= dq_s2_r;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    strobe_select_a: assert property (@(posedge core_clk) disable iff (srst)
        !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
        else $error("write strobe without select or data drive");
    data_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        $rose(flash_we_n) |-> $stable(flash_dq_out) && flash_dq_oe
            && $stable(flash_addr))
        else $error("data or address moved at write strobe rise");
endmodule

/* File: logic/flash_host_ctrl.sv */
// Host controller for a word-wide command-driven flash part.
// Software gives orders over Avalon-MM; the block drives the part's pins.
// Assumes the bidirectional data pins are resolved by the surroundings.
//
// Functional notes
// - Lock pin guards only two outermost blocks
// - Program or erase starts with two writes
// - Wait recovery time before trusting reads
// - Hold reset low during system reset
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int AW = 20,
    parameter bit PARAM_AT_TOP = 1'b1
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [AW-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic reset_powerdown_n,
    output logic flash_wp_n
);
    typedef enum logic [7:0] {
        S_IDLE = 8'b00000001, S_RECOVER = 8'b00000010,
        S_ARRAY_CMD = 8'b00000100, S_READ = 8'b00001000,
        S_CMD1 = 8'b00010000, S_CMD2 = 8'b00100000,
        S_RDSTAT = 8'b01000000, S_POLL = 8'b10000000
    } seq_state_t;

    flash_cycle_if #(.AW(AW)) cyc ();

    seq_state_t state_r;
    op_t op_r;
    logic [AW-1:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic [7:0] dev_stat_r;
    logic pd_req_r;
    logic lock_hit_r;
    logic rejected_r;
    logic issued_r;
    logic req_r;
    logic [7:0] rec_cnt_r;
    logic [7:0] gap_cnt_r;
    logic acc_wr;
    logic go_acc;
    logic go_rej;
    logic outer_blk;
    logic pe_op;
    logic need_cyc;
    op_t new_op;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    assign acc_wr = avs_write && !avs_waitrequest;
    assign new_op = op_t'(avs_writedata[CTRL_OP_LSB +: 3]);
    assign go_acc = acc_wr && avs_address == REG_CTRL
        && avs_writedata[CTRL_GO_BIT] && state_r == S_IDLE
        && reset_powerdown_n && !pd_req_r;
    assign go_rej = acc_wr && avs_address == REG_CTRL
        && avs_writedata[CTRL_GO_BIT] && !go_acc;
    assign pe_op = new_op == OP_PROGRAM || new_op == OP_ERASE;
    // Two outermost 4-Kword blocks at the parameter end of the map
    assign outer_blk = PARAM_AT_TOP ? &addr_r[AW-1:LOCK_SPAN_W]
                                    : ~|addr_r[AW-1:LOCK_SPAN_W];

    // Answer every request after exactly one wait cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read data, taken when the request is first seen
    always_ff @(posedge core_clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
                REG_CTRL: avs_readdata <= 32'({flash_wp_n, pd_req_r, op_r,
                    1'b0});
                REG_ADDR: avs_readdata <= 32'(addr_r);
                REG_WDATA: avs_readdata <= 32'(wdata_r);
                REG_RDATA: avs_readdata <= 32'(rdata_r);
                REG_STATUS: avs_readdata <= 32'({dev_stat_r, 3'h0,
                    rejected_r, lock_hit_r, !reset_powerdown_n,
                    state_r == S_RECOVER, state_r != S_IDLE});
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software-written controls
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pd_req_r <= 1'b0;
            flash_wp_n <= 1'b0;
            addr_r <= '0;
            wdata_r <= 16'h0000;
            op_r <= OP_READ;
        end else begin
            if (acc_wr && avs_address == REG_CTRL) begin
                pd_req_r <= avs_writedata[CTRL_PD_BIT];
                flash_wp_n <= avs_writedata[CTRL_WP_BIT];
            end
            if (acc_wr && avs_address == REG_ADDR) begin
                addr_r <= avs_writedata[AW-1:0];
            end
            if (acc_wr && avs_address == REG_WDATA) begin
                wdata_r <= avs_writedata[DATA_W-1:0];
            end
            if (go_acc) begin
                op_r <= new_op;
            end
        end
    end

    // Sticky flags; a new event wins over a write-one clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lock_hit_r <= 1'b0;
            rejected_r <= 1'b0;
        end else begin
            // The lock level is the one that this same write sets
            if (go_acc && pe_op && outer_blk
                && !avs_writedata[CTRL_WP_BIT]) begin
                lock_hit_r <= 1'b1;
            end else if (acc_wr && avs_address == REG_STATUS
                         && avs_writedata[ST_LOCK_BIT]) begin
                lock_hit_r <= 1'b0;
            end
            if (go_rej) begin
                rejected_r <= 1'b1;
            end else if (acc_wr && avs_address == REG_STATUS
                         && avs_writedata[ST_REJ_BIT]) begin
                rejected_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Reset / power-down pin and recovery
    // ---------------------------------------------------------------
    // Held low through system reset, then released by hardware whenever no power-down is requested
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reset_powerdown_n <= 1'b0;
        end else if (pd_req_r && state_r == S_IDLE) begin
            reset_powerdown_n <= 1'b0;
        end else if (!pd_req_r) begin
            reset_powerdown_n <= 1'b1;
        end
    end

    // Cycles since the pin last rose, saturating at the recovery count
    always_ff @(posedge core_clk) begin
        if (srst || !reset_powerdown_n) begin
            gap_cnt_r <= 8'h00;
        end else if (gap_cnt_r != REC_LOAD) begin
            gap_cnt_r <= gap_cnt_r + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // Command sequencer
    // ---------------------------------------------------------------
    assign need_cyc = state_r != S_IDLE && state_r != S_RECOVER;

    // Cycle content for the current step
    always_comb begin
        cyc.addr = addr_r;
        cyc.wr = 1'b1;
        cyc.wdata = CMD_READ_ARRAY;
        unique case (state_r)
            S_READ, S_POLL: cyc.wr = 1'b0;
            S_CMD1: begin
                unique case (op_r)
                    OP_PROGRAM: cyc.wdata = CMD_PROGRAM;
                    OP_ERASE: cyc.wdata = CMD_ERASE;
                    OP_SUSPEND: cyc.wdata = CMD_SUSPEND;
                    OP_RESUME: cyc.wdata = CMD_RESUME;
                    default: cyc.wdata = CMD_CLEAR_STATUS;
                endcase
            end
            S_CMD2: cyc.wdata = (op_r == OP_PROGRAM) ? wdata_r
                                                     : CMD_CONFIRM;
            S_RDSTAT: cyc.wdata = CMD_READ_STATUS;
            default: cyc.wdata = CMD_READ_ARRAY;
        endcase
    end
    assign cyc.req = req_r;

    // One request each time a step is entered, and again after each answer while S_POLL waits for ready
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_r <= 1'b0;
            issued_r <= 1'b0;
        end else begin
            req_r <= need_cyc && !issued_r && !req_r;
            if (cyc.done) begin
                issued_r <= 1'b0;
            end else if (need_cyc && !issued_r) begin
                issued_r <= 1'b1;
            end
        end
    end

    // Step through the sequence for each order
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= S_IDLE;
            rec_cnt_r <= 8'h00;
            rdata_r <= 16'h0000;
            dev_stat_r <= 8'h00;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (!reset_powerdown_n && !pd_req_r) begin
                        rec_cnt_r <= REC_LOAD;
                        state_r <= S_RECOVER;
                    end else if (go_acc) begin
                        unique case (new_op)
                            OP_READ: state_r <= S_ARRAY_CMD;
                            OP_STATUS: state_r <= S_RDSTAT;
                            default: state_r <= S_CMD1;
                        endcase
                    end
                end
                S_RECOVER: begin
                    if (rec_cnt_r == 8'h01) begin
                        state_r <= S_IDLE;
                    end else begin
                        rec_cnt_r <= rec_cnt_r - 8'h01;
                    end
                end
                S_ARRAY_CMD: if (cyc.done) begin
                    state_r <= (op_r == OP_READ) ? S_READ : S_IDLE;
                end
                S_READ: if (cyc.done) begin
                    rdata_r <= cyc.rdata;
                    state_r <= S_IDLE;
                end
                S_CMD1: if (cyc.done) begin
                    if (op_r == OP_PROGRAM || op_r == OP_ERASE) begin
                        state_r <= S_CMD2;
                    end else if (op_r == OP_SUSPEND) begin
                        state_r <= S_RDSTAT;
                    end else begin
                        state_r <= S_IDLE;
                    end
                end
                S_CMD2: if (cyc.done) state_r <= S_RDSTAT;
                S_RDSTAT: if (cyc.done) state_r <= S_POLL;
                S_POLL: if (cyc.done) begin
                    dev_stat_r <= cyc.rdata[7:0];
                    if (op_r == OP_STATUS) begin
                        state_r <= S_IDLE;
                    end else if (cyc.rdata[DEV_READY_BIT]) begin
                        state_r <= S_ARRAY_CMD;
                    end
                end
            endcase
        end
    end

    flash_cycle_engine #(.AW(AW)) u_engine (
        .core_clk(core_clk),
        .srst(srst),
        .cyc(cyc.eng),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    rp_low_reset_a: assert property (disable iff (1'b0)
        srst |=> !reset_powerdown_n)
        else $error("reset pin not low after system reset");
    pd_quiet_a: assert property (!reset_powerdown_n |-> !cyc.req)
        else $error("bus cycle issued while reset pin low");
    recovery_gap_a: assert property (cyc.req |-> gap_cnt_r == REC_LOAD)
        else $error("cycle issued before recovery time");
    two_write_a: assert property ((state_r == S_CMD1 && cyc.done
        && (op_r == OP_PROGRAM || op_r == OP_ERASE))
        |=> state_r == S_CMD2 ##1 (cyc.req && cyc.wr))
        else $error("setup write not followed by second write");
    second_data_a: assert property ((state_r == S_CMD2 && cyc.req)
        |-> cyc.wdata == ((op_r == OP_PROGRAM) ? wdata_r
                                               : CMD_CONFIRM))
        else $error("second write carries wrong data");
    wp_follow_a: assert property ((acc_wr && avs_address == REG_CTRL)
        |=> flash_wp_n == $past(avs_writedata[CTRL_WP_BIT]))
        else $error("lock pin does not follow control write");
    lock_flag_a: assert property ((go_acc && pe_op && outer_blk
        && !avs_writedata[CTRL_WP_BIT]) |=> lock_hit_r)
        else $error("locked outer block access not flagged");
    bus_answer_a: assert property (((avs_read || avs_write)
        && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not exactly one cycle late");

    prog_seq_c: cover property (go_acc && new_op == OP_PROGRAM);
    erase_seq_c: cover property (state_r == S_CMD2 && op_r == OP_ERASE
        && cyc.done);
    suspend_c: cover property (state_r == S_POLL && op_r == OP_SUSPEND
        && cyc.done);
    read_c: cover property (state_r == S_READ && cyc.done);
endmodule

/* File: tb/flash_dev_model.sv */
// Behavioural word-wide flash part seen from its pins.
// Assumes parameter blocks at the top and the data bus resolved outside.
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int AW = 20,
    parameter int BUSY_NS = 2000
) (
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] din,
    output logic [15:0] dout,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rp_n,
    input wire logic wp_n
);
    logic [15:0] mem [int];
    logic [6:0] sr = 7'h00;
    logic [1:0] pend = 2'd0;
    logic stat_mode = 1'b0;
    logic busy = 1'b0;
    // Outer two 4-Kword blocks locked while the lock pin is low
    wire lk = !wp_n && (&addr[AW-1:13]);
    // Top 32-Kword span holds the 4-Kword parameter blocks
    wire [3:0] blk_sh = (&addr[AW-1:15]) ? 4'd12 : 4'd15;
    initial dout = 16'h0000;
    // Selected reads show array or status
    always @(negedge oe_n or negedge ce_n or addr or busy or stat_mode) begin
        if (!ce_n && !oe_n && rp_n) begin
            if (stat_mode) dout = {8'h00, ~busy, sr};
            else dout = mem.exists(addr) ? mem[addr] : 16'hFFFF;
        end
    end
    // Released bus shows the inverse of the last value
    always @(posedge oe_n or negedge rp_n) dout = ~dout;
    // Commands decode on the write strobe's rising edge
    always @(posedge we_n or negedge rp_n) begin
        if (!rp_n) begin
            sr = 7'h00;
            pend = 2'd0;
            stat_mode = 1'b0;
        end else if (!ce_n) begin
            if (pend != 2'd0) begin
                if (lk) sr = sr | (pend == 2'd1 ? 7'h12 : 7'h22);
                else if (pend == 2'd1) mem[addr] = din;
                else foreach (mem[k])
                    if ((k >> blk_sh) == (addr >> blk_sh))
                        mem[k] = 16'hFFFF;
                stat_mode = 1'b1;
                busy = 1'b1;
                busy <= #BUSY_NS 1'b0;
                pend = 2'd0;
            end else begin
                stat_mode = din[7:0] != 8'hFF;
                if (din[7:0] == 8'h50) sr = 7'h00;
                pend = din[7:0] == 8'h40 ? 2'd1 : din[7:0] == 8'h20 ? 2'd2 : 2'd0;
            end
        end
    end
endmodule

/* File: tb/flash_host_ctrl_bench.sv */
// Bench for the flash host controller: Avalon tasks give software
// orders; assumes the device model answers on the flash pins.
`timescale 1ns/1ps
module flash_host_ctrl_bench
    import flash_host_pkg::*;
;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
    logic reset_powerdown_n, flash_wp_n;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_out, dev_dq, flash_dq_in;
    int n_fail = 0;
    int comparisons = 0;
    always #20 core_clk = ~core_clk;
    // Data pins resolved from the controller's enable
    assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_dq;
    flash_host_ctrl DUT (.core_clk, .srst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n,
        .flash_oe_n, .flash_we_n, .reset_powerdown_n, .flash_wp_n);
    flash_dev_model DEV (.addr(flash_addr), .din(flash_dq_in), .dout(dev_dq),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .rp_n(reset_powerdown_n), .wp_n(flash_wp_n));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk(32'(n), 32'h2);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    // Poll status until neither busy nor recovering
    task automatic idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (q[1:0] !== 2'b00 && n < 400);
        chk({30'h0, q[1:0]}, 32'h0);
    endtask
    task automatic op(input logic [2:0] c, input logic wp);
        bus(1'b1, REG_CTRL, {26'h0, wp, 1'b0, c, 1'b1});
        idle();
    endtask
    task automatic st(input logic [7:0] b, input logic lk);
        chk({23'h0, q[15:8], q[3]}, {23'h0, b, lk});
    endtask
    initial begin
        #2000000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        bus(1'b1, REG_CTRL, 32'h21);
        bus(1'b0, REG_STATUS, 32'h0);
        chk({30'h0, q[4], q[1]}, 32'h3);
        bus(1'b1, REG_STATUS, 32'h18);
        idle();
        bus(1'b1, REG_ADDR, 32'h00100);
        bus(1'b1, REG_WDATA, 32'h1234);
        op(OP_PROGRAM, 1'b1);
        st(8'h80, 1'b0);
        op(OP_READ, 1'b1);
        bus(1'b0, REG_RDATA, 32'h0);
        chk({16'h0, q[15:0]}, 32'h1234);
        chk({31'h0, flash_ce_n}, 32'h1);
        bus(1'b1, REG_ADDR, 32'hFF000);
        op(OP_PROGRAM, 1'b0);
        st(8'h92, 1'b1);
        op(OP_CLRSTAT, 1'b0);
        bus(1'b1, REG_STATUS, 32'h18);
        op(OP_ERASE, 1'b0);
        st(8'hA2, 1'b1);
        bus(1'b1, REG_CTRL, 32'h10);
        bus(1'b1, REG_CTRL, 32'h11);
        bus(1'b0, REG_STATUS, 32'h0);
        chk({29'h0, q[4], q[2], reset_powerdown_n}, 32'h6);
        bus(1'b1, REG_STATUS, 32'h18);
        bus(1'b1, REG_CTRL, 32'h20);
        idle();
        op(OP_STATUS, 1'b1);
        st(8'h80, 1'b0);
        op(OP_SUSPEND, 1'b1);
        st(8'h80, 1'b0);
        op(OP_RESUME, 1'b1);
        chk({31'h0, q[4]}, 32'h0);
        bus(1'b1, REG_WDATA, 32'h5678);
        op(OP_PROGRAM, 1'b1);
        op(OP_READ, 1'b1);
        bus(1'b0, REG_RDATA, 32'h0);
        chk({16'h0, q[15:0]}, 32'h5678);
        op(OP_ERASE, 1'b1);
        st(8'h80, 1'b0);
        op(OP_READ, 1'b1);
        bus(1'b0, REG_RDATA, 32'h0);
        chk({16'h0, q[15:0]}, 32'hFFFF);
        report_and_stop();
    end
endmodule
